// [hdl/ucr_pkg.sv]
// Package: command table, diagnostic byte layout and state types for the command/response engine
`default_nettype none
package ucr_pkg;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned BIT_W = 16;
   localparam logic [2:0]  DIAG_TOP_ZERO = 3'h0;
   localparam logic [1:0]  DIAG_TOP = 2'h1;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [BIT_W-1:0] BIT_ONE = 16'h0001;
   // Command codes
   localparam logic [4:0] CMD_RUN_LAST      = 5'h04;
   localparam logic [4:0] CMD_RESULT_READ   = 5'h05;
   localparam logic [4:0] CMD_TEMP_READ     = 5'h06;
   localparam logic [4:0] CMD_DUMP_READ     = 5'h07;
   localparam logic [4:0] CMD_DIAG_READ     = 5'h08;
   localparam logic [4:0] CMD_REG_READ      = 5'h09;
   localparam logic [4:0] CMD_REG_WRITE     = 5'h0a;
   localparam logic [4:0] CMD_EE_READ       = 5'h0b;
   localparam logic [4:0] CMD_EE_WRITE      = 5'h0c;
   localparam logic [4:0] CMD_GAIN_READ     = 5'h0d;
   localparam logic [4:0] CMD_GAIN_WRITE    = 5'h0e;
   localparam logic [4:0] CMD_THR_READ      = 5'h0f;
   localparam logic [4:0] CMD_THR_WRITE     = 5'h10;
   localparam logic [4:0] CMD_BC_FIRST      = 5'h11;
   localparam logic [4:0] CMD_BC_RUN_LAST   = 5'h14;
   localparam logic [4:0] CMD_BC_REG_WRITE  = 5'h16;
   localparam logic [4:0] CMD_BC_EE_WRITE   = 5'h17;
   localparam logic [4:0] CMD_BC_GAIN_WRITE = 5'h18;
   localparam logic [4:0] CMD_BC_THR_WRITE  = 5'h19;
   localparam logic [4:0] CMD_RSVD_FIRST    = 5'h1a;
   // Byte counts
   localparam logic [CNT_W-1:0] LEN_RUN     = 8'h01;
   localparam logic [CNT_W-1:0] LEN_REG_WR  = 8'h02;
   localparam logic [CNT_W-1:0] LEN_EE      = 8'h2b;
   localparam logic [CNT_W-1:0] LEN_GAIN    = 8'h07;
   localparam logic [CNT_W-1:0] LEN_THR     = 8'h20;
   localparam logic [CNT_W-1:0] LEN_RESULT  = 8'h20;
   localparam logic [CNT_W-1:0] LEN_TEMP    = 8'h02;
   localparam logic [CNT_W-1:0] LEN_DUMP    = 8'h80;
   localparam logic [CNT_W-1:0] LEN_DIAG    = 8'h03;
   localparam logic [CNT_W-1:0] LEN_REG_RD  = 8'h01;

   typedef struct packed {
      logic [2:0] addr;
      logic [4:0] code;
   } ucr_cmd_t;

   typedef struct packed {
      logic [1:0] top;
      logic       b5;
      logic       b4;
      logic       b3;
      logic       b2;
      logic       b1;
      logic       b0;
   } ucr_diag_t;

   // Sticky communication errors, also used for the per-cycle event inputs
   typedef struct packed {
      logic comm;
      logic inv_cmd;
      logic chk;
      logic width;
      logic rate;
   } ucr_err_t;

   // Page-one health inputs
   typedef struct packed {
      logic eeprom_crc;
      logic volt;
      logic freq;
      logic thr_crc;
   } ucr_health_t;

   typedef enum logic [9:0] {
      ST_IDLE  = 10'h001,
      ST_CMD   = 10'h002,
      ST_DATA  = 10'h004,
      ST_CHK   = 10'h008,
      ST_GAP   = 10'h010,
      ST_DIAG  = 10'h020,
      ST_RDREQ = 10'h040,
      ST_RDWT  = 10'h080,
      ST_SEND  = 10'h100,
      ST_SUM   = 10'h200
   } ucr_state_t;

   function automatic logic [CNT_W-1:0] req_len(input logic [4:0] c);
      logic [CNT_W-1:0] n;
      n = CNT_ZERO;
      if (c <= CMD_RUN_LAST || (c >= CMD_BC_FIRST && c < CMD_BC_REG_WRITE)) n = LEN_RUN;
      else if (c == CMD_REG_WRITE || c == CMD_BC_REG_WRITE) n = LEN_REG_WR;
      else if (c == CMD_EE_WRITE || c == CMD_BC_EE_WRITE) n = LEN_EE;
      else if (c == CMD_GAIN_WRITE || c == CMD_BC_GAIN_WRITE) n = LEN_GAIN;
      else if (c == CMD_THR_WRITE || c == CMD_BC_THR_WRITE) n = LEN_THR;
      return n;
   endfunction

   function automatic logic [CNT_W-1:0] resp_len(input logic [4:0] c);
      logic [CNT_W-1:0] n;
      n = CNT_ZERO;
      unique case (c)
         CMD_RESULT_READ: n = LEN_RESULT;
         CMD_TEMP_READ:   n = LEN_TEMP;
         CMD_DUMP_READ:   n = LEN_DUMP;
         CMD_DIAG_READ:   n = LEN_DIAG;
         CMD_REG_READ:    n = LEN_REG_RD;
         CMD_EE_READ:     n = LEN_EE;
         CMD_GAIN_READ:   n = LEN_GAIN;
         CMD_THR_READ:    n = LEN_THR;
         default:         n = CNT_ZERO;
      endcase
      return n;
   endfunction

   function automatic logic is_run(input logic [4:0] c);
      return (c <= CMD_RUN_LAST) || (c >= CMD_BC_FIRST && c <= CMD_BC_RUN_LAST);
   endfunction
endpackage
`default_nettype wire

// [hdl/ucr_checksum.sv]
// Running checksum: carry-wrapped byte sum, inverted on output
`default_nettype none
module ucr_checksum (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Accumulate control
   input  wire logic       clr,
   input  wire logic       add,
   input  wire logic [7:0] byte_in,
   // Result
   output logic      [7:0] sum
);
   typedef struct packed {
      logic [7:0] acc;
   } ucr_chk_state_t;

   ucr_chk_state_t q_ff;
   ucr_chk_state_t nxt_q;
   logic [8:0]     wide;

   always_comb begin
      nxt_q = q_ff;
      wide  = {1'b0, q_ff.acc} + {1'b0, byte_in};
      if (clr) begin
         nxt_q.acc = 8'h00;
      end else if (add) begin
         nxt_q.acc = wide[7:0] + {7'h00, wide[8]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign sum = ~q_ff.acc;
endmodule // ucr_checksum
`default_nettype wire

// [hdl/ucr_engine.sv]
// Command/response engine: frame decode, write strobes, response with diagnostic byte and checksum
`default_nettype none
// Summary of operation
// R01: Controller waits 50 us after any bulk write before reading.
// R02: Controller waits 60 us after gain/threshold register write, else 3.3 us.
// R03: Diagnostic readout before any run command is flagged as invalid data.
// R04: Result read while echo dump enabled is flagged as invalid or stale.
// R05: Command byte holds address and code; fixed data byte count is stored.
// R06: Controller ends a no-response frame with its checksum.
// R07: New no-response command aborts busy work and executes at once.
// R08: Response requests carry no checksum; device sends data and checksum.
// R09: One bit period of silence before the response starts.
// R10: Register read takes one address byte plus checksum, then normal response.
// R11: Request while busy gets a diagnostic byte with busy bit set.
// R12: New request during a response is ignored until it completes.
// R13: Every response begins with the diagnostic byte.
// R14: Error bits latch between responses and clear after a response.
// R15: Diagnostic byte is included in the response checksum.
// R16: Diagnostic bits 7:6 always sent as 01.
// R17: Page 0: bit 0 busy, bit 1 sync bit rate out of range.
// R18: Page 0: bit 2 sync width mismatch, bit 3 checksum, bit 4 invalid command.
// R19: Page 0: bit 5 general communication error.
// R20: Page 1: threshold CRC, frequency, voltage, zero, EEPROM/trim CRC.
// R21: Both ends use the same checksum over the covered bytes.
module ucr_engine (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // Received bytes
   input  wire logic                    frame_start,
   input  wire logic                    rx_valid,
   input  wire logic [7:0]              rx_data,
   // Configuration and status
   input  wire logic [2:0]              dev_addr,
   input  wire logic [15:0]             bit_period,
   input  wire logic                    diag_page_select,
   input  wire logic                    echo_dump_en,
   input  wire logic                    busy_in,
   input  wire ucr_pkg::ucr_err_t       err_event,
   input  wire ucr_pkg::ucr_health_t    health,
   // Stored data and command execution
   output logic                         wr_valid,
   output logic [7:0]                   wr_idx,
   output logic [7:0]                   wr_data,
   output logic                         exec,
   output logic                         abort,
   output logic [4:0]                   exec_cmd,
   // Response data fetch
   output logic                         rd_req,
   output logic [4:0]                   rd_cmd,
   output logic [7:0]                   rd_idx,
   output logic [7:0]                   rd_reg,
   input  wire logic                    rd_valid,
   input  wire logic [7:0]              rd_data,
   output logic                         resp_data_invalid,
   // Transmit bytes
   output logic                         tx_valid,
   output logic [7:0]                   tx_data,
   input  wire logic                    tx_ready,
   // Sticky error view
   output ucr_pkg::ucr_err_t            err_status
);
   typedef struct packed {
      ucr_pkg::ucr_state_t st;
      logic [4:0]          cmd;
      logic                reg_read;
      logic [7:0]          cnt;
      logic [7:0]          idx;
      logic [15:0]         gap;
      logic                busy_resp;
      logic                ran;
      ucr_pkg::ucr_err_t   err;
      logic                wr_valid;
      logic [7:0]          wr_data;
      logic                exec;
      logic                abort;
      logic                rd_req;
      logic [7:0]          rd_reg;
      logic                invalid;
      logic                tx_valid;
      logic [7:0]          tx_data;
   } ucr_eng_state_t;

   ucr_eng_state_t      q_ff;
   ucr_eng_state_t      nxt_q;
   ucr_pkg::ucr_cmd_t   cmd_in;
   ucr_pkg::ucr_diag_t  diag;
   logic                chk_clr;
   logic                chk_add;
   logic [7:0]          chk_byte;
   logic [7:0]          chk_sum;
   logic                tx_done;
   logic                resp_end;

   ucr_checksum u_chk (
      .clk     (clk),
      .rst     (rst),
      .clr     (chk_clr),
      .add     (chk_add),
      .byte_in (chk_byte),
      .sum     (chk_sum)
   );

   // Diagnostic byte for the selected page
   always_comb begin
      diag.top = ucr_pkg::DIAG_TOP; // R16
      diag.b0  = q_ff.busy_resp; // R11 R17
      if (!diag_page_select) begin
         diag.b1 = q_ff.err.rate; // R17
         diag.b2 = q_ff.err.width; // R18
         diag.b3 = q_ff.err.chk; // R18
         diag.b4 = q_ff.err.inv_cmd; // R18
         diag.b5 = q_ff.err.comm; // R19
      end else begin
         diag.b1 = health.thr_crc; // R20
         diag.b2 = health.freq; // R20
         diag.b3 = health.volt; // R20
         diag.b4 = 1'b0; // R20
         diag.b5 = health.eeprom_crc; // R20
      end
   end

   assign cmd_in  = ucr_pkg::ucr_cmd_t'(rx_data);
   assign tx_done = q_ff.tx_valid && tx_ready;

   always_comb begin
      nxt_q          = q_ff;
      nxt_q.wr_valid = 1'b0;
      nxt_q.exec     = 1'b0;
      nxt_q.abort    = 1'b0;
      nxt_q.rd_req   = 1'b0;
      chk_clr        = 1'b0;
      chk_add        = 1'b0;
      chk_byte       = rx_data;
      resp_end       = 1'b0;
      unique case (q_ff.st)
         ucr_pkg::ST_IDLE: begin
            if (frame_start) begin
               chk_clr  = 1'b1;
               nxt_q.st = ucr_pkg::ST_CMD;
            end
         end
         ucr_pkg::ST_CMD: begin
            if (rx_valid) begin
               chk_add        = 1'b1; // R21
               nxt_q.cmd      = cmd_in.code; // R05
               nxt_q.idx      = ucr_pkg::CNT_ZERO;
               nxt_q.reg_read = (cmd_in.code == ucr_pkg::CMD_REG_READ);
               nxt_q.st       = ucr_pkg::ST_IDLE;
               if (cmd_in.code >= ucr_pkg::CMD_RSVD_FIRST) begin
                  nxt_q.err.inv_cmd = 1'b1; // R18
               end else if (cmd_in.addr == dev_addr || cmd_in.code >= ucr_pkg::CMD_BC_FIRST) begin
                  if (cmd_in.code == ucr_pkg::CMD_REG_READ) begin
                     nxt_q.cnt = ucr_pkg::LEN_REG_RD; // R10
                     nxt_q.st  = ucr_pkg::ST_DATA;
                  end else if (ucr_pkg::resp_len(cmd_in.code) != ucr_pkg::CNT_ZERO) begin
                     // Response request: no checksum from the controller
                     chk_clr         = 1'b1; // R08
                     nxt_q.busy_resp = busy_in; // R11
                     nxt_q.cnt       = busy_in ? ucr_pkg::CNT_ZERO : ucr_pkg::resp_len(cmd_in.code);
                     nxt_q.invalid   = (cmd_in.code == ucr_pkg::CMD_DIAG_READ && !q_ff.ran) // R03
                                    || (cmd_in.code == ucr_pkg::CMD_RESULT_READ && echo_dump_en); // R04
                     nxt_q.gap       = bit_period;
                     nxt_q.st        = ucr_pkg::ST_GAP;
                  end else begin
                     nxt_q.cnt = ucr_pkg::req_len(cmd_in.code); // R05
                     nxt_q.st  = (ucr_pkg::req_len(cmd_in.code) == ucr_pkg::CNT_ZERO) ? ucr_pkg::ST_CHK
                                                                                      : ucr_pkg::ST_DATA;
                  end
               end
            end
         end
         ucr_pkg::ST_DATA: begin
            if (rx_valid) begin
               chk_add   = 1'b1;
               nxt_q.idx = q_ff.idx + ucr_pkg::CNT_ONE;
               nxt_q.cnt = q_ff.cnt - ucr_pkg::CNT_ONE;
               if (q_ff.reg_read) begin
                  nxt_q.rd_reg = rx_data; // R10
               end else begin
                  nxt_q.wr_valid = 1'b1; // R05
                  nxt_q.wr_data  = rx_data;
               end
               if (q_ff.cnt == ucr_pkg::CNT_ONE) begin
                  nxt_q.st = ucr_pkg::ST_CHK;
               end
            end
         end
         ucr_pkg::ST_CHK: begin
            if (rx_valid) begin
               nxt_q.st = ucr_pkg::ST_IDLE;
               if (rx_data != chk_sum) begin
                  nxt_q.err.chk = 1'b1; // R06 R18 R21
               end else if (q_ff.reg_read) begin
                  chk_clr         = 1'b1;
                  nxt_q.busy_resp = busy_in; // R11
                  nxt_q.cnt       = busy_in ? ucr_pkg::CNT_ZERO : ucr_pkg::LEN_REG_RD;
                  nxt_q.invalid   = 1'b0;
                  nxt_q.idx       = ucr_pkg::CNT_ZERO;
                  nxt_q.gap       = bit_period;
                  nxt_q.st        = ucr_pkg::ST_GAP; // R10
               end else begin
                  nxt_q.exec  = 1'b1; // R07
                  nxt_q.abort = busy_in; // R07
                  if (ucr_pkg::is_run(q_ff.cmd)) begin
                     nxt_q.ran = 1'b1; // R03
                  end
               end
            end
         end
         ucr_pkg::ST_GAP: begin
            // Line stays idle one bit time
            nxt_q.gap = q_ff.gap - ucr_pkg::BIT_ONE;
            if (q_ff.gap <= ucr_pkg::BIT_ONE) begin
               nxt_q.st       = ucr_pkg::ST_DIAG; // R09
               nxt_q.tx_valid = 1'b1; // R13
               nxt_q.tx_data  = diag;
               chk_add        = 1'b1; // R15
               chk_byte       = diag;
            end
         end
         ucr_pkg::ST_DIAG: begin
            if (tx_done) begin
               nxt_q.tx_valid = 1'b0;
               nxt_q.st = (q_ff.cnt == ucr_pkg::CNT_ZERO) ? ucr_pkg::ST_SUM : ucr_pkg::ST_RDREQ; // R11
            end
         end
         ucr_pkg::ST_RDREQ: begin
            nxt_q.rd_req = 1'b1; // R08
            nxt_q.st     = ucr_pkg::ST_RDWT;
         end
         ucr_pkg::ST_RDWT: begin
            if (rd_valid) begin
               nxt_q.tx_valid = 1'b1;
               nxt_q.tx_data  = rd_data;
               chk_add        = 1'b1; // R08
               chk_byte       = rd_data;
               nxt_q.st       = ucr_pkg::ST_SEND;
            end
         end
         ucr_pkg::ST_SEND: begin
            if (tx_done) begin
               nxt_q.tx_valid = 1'b0;
               nxt_q.idx      = q_ff.idx + ucr_pkg::CNT_ONE;
               nxt_q.cnt      = q_ff.cnt - ucr_pkg::CNT_ONE;
               nxt_q.st = (q_ff.cnt == ucr_pkg::CNT_ONE) ? ucr_pkg::ST_SUM : ucr_pkg::ST_RDREQ;
            end
         end
         ucr_pkg::ST_SUM: begin
            if (!q_ff.tx_valid) begin
               nxt_q.tx_valid = 1'b1; // R08
               nxt_q.tx_data  = chk_sum;
            end else if (tx_ready) begin
               nxt_q.tx_valid = 1'b0;
               resp_end       = 1'b1;
               nxt_q.st       = ucr_pkg::ST_IDLE;
            end
         end
      endcase
      // Clear after a response, then new events set (set wins)
      if (resp_end) begin
         nxt_q.err = '0; // R14
      end
      nxt_q.err = nxt_q.err | err_event; // R14
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_ff    <= '0;
         q_ff.st <= ucr_pkg::ST_IDLE;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign wr_valid          = q_ff.wr_valid;
   assign wr_idx            = q_ff.idx;
   assign wr_data           = q_ff.wr_data;
   assign exec              = q_ff.exec;
   assign abort             = q_ff.abort;
   assign exec_cmd          = q_ff.cmd;
   assign rd_req            = q_ff.rd_req;
   assign rd_cmd            = q_ff.cmd;
   assign rd_idx            = q_ff.idx;
   assign rd_reg            = q_ff.rd_reg;
   assign resp_data_invalid = q_ff.invalid;
   assign tx_valid          = q_ff.tx_valid;
   assign tx_data           = q_ff.tx_data;
   assign err_status        = q_ff.err;

   a_gap_before_tx: assert property (@(posedge clk) disable iff (rst) // R09
      $rose(q_ff.tx_valid) && q_ff.st == ucr_pkg::ST_DIAG |-> $past(q_ff.st == ucr_pkg::ST_GAP))
      else $error("Response started without the one bit gap");
   a_diag_top_bits: assert property (@(posedge clk) disable iff (rst) // R16
      q_ff.tx_valid && q_ff.st == ucr_pkg::ST_DIAG |-> q_ff.tx_data[7:6] == ucr_pkg::DIAG_TOP)
      else $error("Diagnostic top bits not 01");
   a_diag_first: assert property (@(posedge clk) disable iff (rst) // R13
      q_ff.st == ucr_pkg::ST_GAP ##1 q_ff.st != ucr_pkg::ST_GAP |-> q_ff.st == ucr_pkg::ST_DIAG)
      else $error("Response did not start with diagnostic byte");
   a_busy_diag_only: assert property (@(posedge clk) disable iff (rst) // R11
      q_ff.st == ucr_pkg::ST_DIAG && q_ff.busy_resp && tx_done
      |-> q_ff.tx_data[0] ##1 q_ff.st == ucr_pkg::ST_SUM)
      else $error("Busy request did not get diagnostic only with busy bit");
   a_err_cleared: assert property (@(posedge clk) disable iff (rst) // R14
      q_ff.st == ucr_pkg::ST_SUM && tx_done |=> q_ff.err == $past(err_event))
      else $error("Error bits not cleared after response");
   a_abort_with_exec: assert property (@(posedge clk) disable iff (rst) // R07
      q_ff.st == ucr_pkg::ST_CHK && rx_valid && rx_data == chk_sum && !q_ff.reg_read && busy_in
      |=> q_ff.exec && q_ff.abort)
      else $error("Busy work not aborted by new command");
   a_ignore_request: assert property (@(posedge clk) disable iff (rst) // R12
      frame_start && (q_ff.st == ucr_pkg::ST_SEND || q_ff.st == ucr_pkg::ST_RDWT) |=> q_ff.st != ucr_pkg::ST_CMD)
      else $error("New request taken during a response");
   a_chk_mismatch: assert property (@(posedge clk) disable iff (rst) // R18
      q_ff.st == ucr_pkg::ST_CHK && rx_valid && rx_data != chk_sum |=> q_ff.err.chk && !q_ff.exec)
      else $error("Checksum mismatch not flagged");
   a_page1_zero: assert property (@(posedge clk) disable iff (rst) // R20
      $rose(q_ff.tx_valid) && q_ff.st == ucr_pkg::ST_DIAG && $past(diag_page_select) |-> !q_ff.tx_data[4])
      else $error("Page one bit 4 not zero");
   a_diag_invalid: assert property (@(posedge clk) disable iff (rst) // R03
      q_ff.st == ucr_pkg::ST_CMD && rx_valid && cmd_in.code == ucr_pkg::CMD_DIAG_READ
      && cmd_in.addr == dev_addr && !busy_in && !q_ff.ran |=> q_ff.invalid)
      else $error("Diagnostic readout before run not flagged");
endmodule // ucr_engine
`default_nettype wire

// [sim/ucr_far_model.sv]
// Far-side model: response data source and transmit serializer
`default_nettype none
module ucr_far_model (
   // Clock
   input  wire logic       clk,
   // Data fetch
   input  wire logic       rd_req,
   input  wire logic [7:0] rd_idx,
   output logic            rd_valid,
   output logic [7:0]      rd_data,
   // Serializer
   output logic            tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   integer seed = 25;
   int     lat  = -1;
   initial begin
      rd_valid = 1'b0;
      rd_data  = 8'h00;
      tx_ready = 1'b0;
   end
   always @(posedge clk) begin
      tx_ready <= 1'($random(seed));
      rd_valid <= 1'b0;
      rd_data  <= ~rd_data;
      if (lat > 0) lat <= lat - 1;
      if (lat == 0) begin
         rd_valid <= 1'b1;
         rd_data  <= 8'ha5 ^ rd_idx;
         lat      <= -1;
      end
      if (rd_req) lat <= {$random(seed)} % 4;
   end
endmodule // ucr_far_model
`default_nettype wire

// [sim/tb_ucr_engine.sv]
// Testbench for the command/response engine
`default_nettype none
module tb_ucr_engine;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk, rst, frame_start, rx_valid, diag_page_select, echo_dump_en, busy_in;
   logic [7:0]           rx_data, wr_idx, wr_data, rd_idx, rd_reg, rd_data, tx_data;
   logic [2:0]           dev_addr;
   logic [15:0]          bit_period;
   ucr_pkg::ucr_err_t    err_event, err_status;
   ucr_pkg::ucr_health_t health;
   logic                 wr_valid, exec, abort, rd_req, rd_valid, resp_data_invalid, tx_valid, tx_ready;
   logic [4:0]           exec_cmd, rd_cmd;
   logic [7:0]           txq[$], wrq[$], sq[$];
   logic [5:0]           exq[$];
   logic                 gap_seen, inv_chk;
   integer               seed = 25;
   int                   n_mismatch = 0, check_count = 0, cyc = 0, t_cmd = 0;
   localparam int        WR_RD_WAIT = 15000; // 60 us of 4 ns cycles between a write and a read
   ucr_engine dut_u (.clk, .rst, .frame_start, .rx_valid, .rx_data, .dev_addr, .bit_period, .diag_page_select,
      .echo_dump_en, .busy_in, .err_event, .health, .wr_valid, .wr_idx, .wr_data, .exec, .abort, .exec_cmd,
      .rd_req, .rd_cmd, .rd_idx, .rd_reg, .rd_valid, .rd_data, .resp_data_invalid, .tx_valid, .tx_data,
      .tx_ready, .err_status);
   ucr_far_model far_u (.clk, .rd_req, .rd_idx, .rd_valid, .rd_data, .tx_ready);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [7:0] csum(input logic [7:0] q[$]);
      logic [8:0] s;
      s = 9'h000;
      foreach (q[i]) begin
         s = s[7:0] + q[i];
         s = s[7:0] + s[8];
      end
      return ~s[7:0];
   endfunction
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 40000) begin
         n_mismatch++;
         test_done();
      end
      if (rx_valid) t_cmd = cyc;
      if (tx_valid && tx_ready) txq.push_back(tx_data);
      if (wr_valid) wrq.push_back(wr_data);
      if (wr_valid) cmp(wr_idx, wrq.size());
      if (exec) exq.push_back({abort, exec_cmd});
      if (tx_valid && !gap_seen) begin
         gap_seen = 1'b1;
         cmp(cyc - t_cmd >= bit_period, 1);
         cmp(resp_data_invalid, inv_chk);
      end
   end
   task automatic frame(input logic [7:0] q[$]);
      @(negedge clk);
      frame_start = 1'b1;
      @(negedge clk);
      frame_start = 1'b0;
      foreach (q[i]) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data  = q[i];
         @(negedge clk);
         rx_valid = 1'b0;
         @(negedge clk);
      end
   endtask
   task automatic frame_w(input logic [4:0] code, input int n, input logic good);
      sq = {};
      sq.push_back({dev_addr, code});
      for (int i = 0; i < n; i++) sq.push_back(8'($random(seed)));
      sq.push_back(good ? csum(sq) : ~csum(sq));
      wrq = {};
      exq = {};
      frame(sq);
      repeat (6) @(negedge clk);
   endtask
   task automatic resp(input logic [4:0] code, input int n, input logic [7:0] dg, input logic dup, input int ra);
      logic [7:0] e[$];
      logic [7:0] c[$];
      e.push_back(dg);
      for (int i = 0; i < n; i++) e.push_back(8'ha5 ^ i[7:0]);
      e.push_back(csum(e));
      c.push_back({dev_addr, code});
      if (ra >= 0) c.push_back(ra[7:0]);
      if (ra >= 0) c.push_back(csum(c));
      txq = {};
      gap_seen = 1'b0;
      frame(c);
      for (int k = 0; k < 2000 && txq.size() < 1; k++) @(posedge clk);
      c[0] = {dev_addr, ucr_pkg::CMD_RESULT_READ};
      if (dup) frame(c);
      for (int k = 0; k < 2000 && txq.size() < e.size(); k++) @(posedge clk);
      repeat (40) @(negedge clk);
      cmp(txq.size(), e.size());
      foreach (e[i]) cmp(txq[i], e[i]);
      cmp(rd_cmd, code);
      if (ra >= 0) cmp(rd_reg, ra[7:0]);
   endtask
   initial begin
      rst              = 1'b1;
      frame_start      = 1'b0;
      rx_valid         = 1'b0;
      rx_data          = 8'h00;
      dev_addr         = 3'h5;
      bit_period       = 16'h0008;
      diag_page_select = 1'b0;
      echo_dump_en     = 1'b0;
      busy_in          = 1'b1;
      err_event        = 5'h00;
      health           = 4'h0;
      gap_seen         = 1'b1;
      inv_chk          = 1'b0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      frame_w(ucr_pkg::CMD_REG_WRITE, 2, 1'b1);
      cmp(wrq.size(), 2);
      foreach (wrq[i]) cmp(wrq[i], sq[i+1]);
      cmp(exq.size(), 1);
      cmp(exq[0], {1'b1, ucr_pkg::CMD_REG_WRITE});
      busy_in = 1'b0;
      frame_w(ucr_pkg::CMD_REG_WRITE, 2, 1'b0);
      cmp(exq.size(), 0);
      frame_w(ucr_pkg::CMD_RSVD_FIRST, 0, 1'b1);
      repeat (WR_RD_WAIT) @(negedge clk);
      @(negedge clk);
      err_event = 5'h01;
      @(negedge clk);
      err_event = 5'h00;
      @(negedge clk);
      cmp(err_status, 5'h0d);
      inv_chk = 1'b1;
      resp(ucr_pkg::CMD_DIAG_READ, 3, {2'h1, 5'h0d, 1'b0}, 1'b1, -1);
      inv_chk = 1'b0;
      cmp(err_status, 5'h00);
      health = 4'($random(seed));
      diag_page_select = 1'b1;
      busy_in = 1'b1;
      resp(ucr_pkg::CMD_TEMP_READ, 0, {2'h1, health.eeprom_crc, 1'b0, health.volt, health.freq,
         health.thr_crc, 1'b1}, 1'b0, -1);
      busy_in = 1'b0;
      diag_page_select = 1'b0;
      frame_w(ucr_pkg::CMD_RUN_LAST, 1, 1'b1);
      cmp(exq.size(), 1);
      cmp(exq[0], {1'b0, ucr_pkg::CMD_RUN_LAST});
      echo_dump_en = 1'b1;
      inv_chk = 1'b1;
      resp(ucr_pkg::CMD_RESULT_READ, 32, 8'h40, 1'b0, -1);
      echo_dump_en = 1'b0;
      inv_chk = 1'b0;
      resp(ucr_pkg::CMD_REG_READ, 1, 8'h40, 1'b0, {$random(seed)} % 256);
      test_done();
   end
endmodule // tb_ucr_engine
`default_nettype wire
